// file: rtl/nvcg_defs.svh
// offsets, field positions, factory values and timing of the config and lock guard
`ifndef NVCG_DEFS_SVH
`define NVCG_DEFS_SVH
`define NVCG_OFS_OSC        4'h2
`define NVCG_OFS_CFGA       4'h5
`define NVCG_OFS_CFGB       4'h6
`define NVCG_OFS_CODE       4'h7
`define NVCG_OFS_BOOT       4'h8
`define NVCG_FUSE_LAST      4'h8
`define NVCG_MASK_OSC       8'h0f
`define NVCG_MASK_CFGA      8'he9
`define NVCG_MASK_CFGB      8'h1f
`define NVCG_FACT_CFGA      8'hc0
`define NVCG_FACT_CFGB      8'h08
`define NVCG_FACT_OTHER     8'h00
`define NVCG_UNLOCK_KEY     32'h5cc5c55c
`define NVCG_DENY_DATA      8'hff
`define NVCG_OSC_SEL_MSB    3
`define NVCG_SCAN_REG_LSB   6
`define NVCG_SCAN_POLY_BIT  5
`define NVCG_RST_ROLE_BIT   3
`define NVCG_EE_RETAIN_BIT  0
`define NVCG_SUPPLY_LSB     3
`define NVCG_DELAY_MSB      2
`define NVCG_OSC_FAST       4'h0
`define NVCG_OSC_SLOW       4'h1
`define NVCG_SCAN_OFF       2'h3
`define NVCG_SUPPLY_DUAL    2'h1
`define NVCG_SUPPLY_SINGLE  2'h2
`define NVCG_BLOCK_SHIFT    9
`define NVCG_CLK_PS         8000
`define NVCG_MS_PS          1000000000
`define NVCG_MS_CYC         (`NVCG_MS_PS / `NVCG_CLK_PS)
`endif

// file: rtl/nvcg_pkg.sv
// types of the config and lock guard
package nvcg_pkg;
  typedef enum logic [2:0] {
    RG_FLASH  = 3'b000,
    RG_SRAM   = 3'b001,
    RG_EEPROM = 3'b010,
    RG_USER   = 3'b011,
    RG_SIG    = 3'b100,
    RG_FUSE   = 3'b101,
    RG_LOCK   = 3'b110,
    RG_REGS   = 3'b111
  } nvcg_region_t;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } nvcg_state_t;
endpackage

// file: rtl/nvcg_acc_if.sv
// access request and permission answer between core and gate
`timescale 1ns/1ps
interface nvcg_acc_if;
  import nvcg_pkg::*;
  nvcg_region_t region;
  logic         write;
  logic         from_ext;
  logic         cfg_cmd;
  logic         locked;
  logic         allow;
  modport gate (input region, input write, input from_ext, input cfg_cmd, input locked,
                output allow);
  modport core (output region, output write, output from_ext, output cfg_cmd, output locked,
                input allow);
endinterface

// file: rtl/nvcg_gate.sv
// access permission table for cpu and external port
`timescale 1ns/1ps
module nvcg_gate (
  // request and answer
  nvcg_acc_if.gate acc
);
  import nvcg_pkg::*;
  always_comb begin
    acc.allow = 1'b1;
    if (!acc.from_ext) begin
      // cpu sees the same table locked or not
      if (acc.write && (acc.region inside {RG_SIG, RG_FUSE, RG_LOCK})) begin
        acc.allow = 1'b0; // [RQ14] [RQ15] [RQ20]
      end
    end else if (acc.locked) begin
      acc.allow = acc.write && (acc.region == RG_USER) && acc.cfg_cmd; // [RQ13] [RQ15] [RQ16]
    end else if (acc.write && (acc.region == RG_SIG)) begin
      acc.allow = 1'b0; // [RQ14]
    end
  end
endmodule

// file: rtl/nvcg_top.sv
// start-up configuration loader and memory lock guard
//
// Overview of operation
// [RQ1] clock field code 0 picks fast internal oscillator, 1 the slow one
// [RQ2] scan region field: all flash, boot, boot plus code, or no check
// [RQ3] scan polynomial bit: zero 16-bit CCITT, one 32-bit Ethernet
// [RQ4] reset pin role bit: zero no external reset, one reset with pull-up
// [RQ5] retention bit zero erases eeprom on full erase, one keeps it
// [RQ6] when locked a full erase always clears the eeprom
// [RQ7] supply field: 1 dual, 2 single, 0 and 3 reserved
// [RQ8] start-up delay code 0 none, 1..7 give 1 to 64 ms
// [RQ9] code size byte counts boot plus code in 512-byte blocks
// [RQ10] boot size in 512-byte blocks; zero makes all flash boot
// [RQ11] factory contents 0xc0 and 0x08 for the two system bytes
// [RQ12] any key other than the unlock key locks the part
// [RQ13] locked: external port reads nothing; cpu access unchanged
// [RQ14] unlocked: cpu cannot write signature, config, key; external skips signature
// [RQ15] locked: external denied all but user row writes; cpu unchanged
// [RQ16] locked user row written only by config-write command, never read back
// [RQ17] denied external reads complete but return invalid data
// [RQ18] only a full erase unlocks the part, issued by the host
// [RQ19] stored values copied to targets at end of start-up only; the code copies them in ST_LOAD, before the start-up delay
// [RQ20] cpu and external may read config; only external may write it
// [RQ21] key 0x5cc5c55c means unlocked; factory ships that key
// [RQ22] loaded values held stable in read-only shadows until reset
`timescale 1ns/1ps
`include "nvcg_defs.svh"
module nvcg_top #(
  parameter int MS_CYCLES = `NVCG_MS_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // factory programming
  input  wire logic                 factory_init,
  // cpu port
  input  wire logic                 cpu_req,
  input  wire logic                 cpu_we,
  input  wire nvcg_pkg::nvcg_region_t cpu_region,
  input  wire logic [7:0]           cpu_addr,
  output logic                      cpu_ack,
  output logic                      cpu_denied,
  output logic [7:0]                cpu_rdata,
  // external program/debug port
  input  wire logic                 ext_req,
  input  wire logic                 ext_we,
  input  wire logic                 ext_cfg_cmd,
  input  wire logic                 ext_erase,
  input  wire nvcg_pkg::nvcg_region_t ext_region,
  input  wire logic [7:0]           ext_addr,
  input  wire logic [7:0]           ext_wdata,
  output logic                      ext_ack,
  output logic                      ext_denied,
  output logic [7:0]                ext_rdata,
  // memory side of the external path
  output logic                      mem_req,
  output logic                      mem_we,
  output nvcg_pkg::nvcg_region_t    mem_region,
  output logic [7:0]                mem_addr,
  output logic [7:0]                mem_wdata,
  input  wire logic [7:0]           mem_rdata,
  output logic                      erase_flash,
  output logic                      erase_eeprom,
  // status
  output logic                      cpu_run,
  output logic                      locked,
  // loaded configuration
  output logic [3:0]                default_osc_choice,
  output logic                      internal_fast_osc,
  output logic                      internal_slow_osc,
  output logic [1:0]                scan_region_sel,
  output logic                      scan_disabled,
  output logic                      scan_boot_and_app,
  output logic                      scan_poly_sel,
  output logic                      reset_pin_role,
  output logic                      eeprom_retain,
  output logic [1:0]                supply_arrangement,
  output logic                      multi_voltage_io,
  output logic                      supply_reserved,
  output logic [2:0]                startup_delay_sel,
  output logic [7:0]                code_region_size,
  output logic [7:0]                boot_region_size,
  output logic                      boot_all_flash,
  output logic [16:0]               boot_region_bytes,
  output logic [16:0]               application_code_region
);
  import nvcg_pkg::*;

  localparam int MS_W = $clog2(MS_CYCLES + 1);

  function automatic logic [7:0] nvcg_mask(input logic [3:0] idx);
    unique case (idx)
      `NVCG_OFS_OSC:  nvcg_mask = `NVCG_MASK_OSC;
      `NVCG_OFS_CFGA: nvcg_mask = `NVCG_MASK_CFGA;
      `NVCG_OFS_CFGB: nvcg_mask = `NVCG_MASK_CFGB;
      `NVCG_OFS_CODE: nvcg_mask = 8'hff;
      `NVCG_OFS_BOOT: nvcg_mask = 8'hff;
      default:        nvcg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] nvcg_key_byte(input logic [31:0] k, input logic [1:0] b);
    nvcg_key_byte = k[{b, 3'h0} +: 8];
  endfunction

  function automatic logic [6:0] nvcg_delay_ms(input logic [2:0] code);
    nvcg_delay_ms = 7'h01 << (code - 3'h1); // [RQ8]
  endfunction

  // non-volatile store; survives sys_rst on purpose
  logic [7:0]  fuse_mem [0:8];
  logic [31:0] lock_key;

  nvcg_state_t       state;
  nvcg_state_t       next_state;
  logic [MS_W-1:0]   ms_cnt;
  logic [MS_W-1:0]   next_ms_cnt;
  logic [6:0]        ms_done;
  logic [6:0]        next_ms_done;
  logic [7:0]        sh_osc, sh_a, sh_b, sh_code, sh_boot;
  logic [7:0]        next_osc, next_a, next_b, next_code, next_boot;

  nvcg_acc_if cpu_acc ();
  nvcg_acc_if ext_acc ();

  nvcg_gate u_cpu_gate (
    .acc (cpu_acc.gate)
  );
  nvcg_gate u_ext_gate (
    .acc (ext_acc.gate)
  );

  assign locked = (lock_key != `NVCG_UNLOCK_KEY); // [RQ12] [RQ21]

  assign cpu_acc.region   = cpu_region;
  assign cpu_acc.write    = cpu_we;
  assign cpu_acc.from_ext = 1'b0;
  assign cpu_acc.cfg_cmd  = 1'b0;
  assign cpu_acc.locked   = locked;
  assign ext_acc.region   = ext_region;
  assign ext_acc.write    = ext_we;
  assign ext_acc.from_ext = 1'b1;
  assign ext_acc.cfg_cmd  = ext_cfg_cmd;
  assign ext_acc.locked   = locked;

  // start-up sequence and shadow load
  always_comb begin
    next_state   = state;
    next_ms_cnt  = ms_cnt;
    next_ms_done = ms_done;
    next_osc     = sh_osc;
    next_a       = sh_a;
    next_b       = sh_b;
    next_code    = sh_code;
    next_boot    = sh_boot;
    unique case (state)
      ST_LOAD: begin
        // only place the shadows change, so new fuse values wait for reset
        next_osc     = fuse_mem[`NVCG_OFS_OSC]; // [RQ19] [RQ22]
        next_a       = fuse_mem[`NVCG_OFS_CFGA];
        next_b       = fuse_mem[`NVCG_OFS_CFGB];
        next_code    = fuse_mem[`NVCG_OFS_CODE];
        next_boot    = fuse_mem[`NVCG_OFS_BOOT];
        next_ms_cnt  = '0;
        next_ms_done = 7'h00;
        next_state   = ST_WAIT;
      end
      ST_WAIT: begin
        if (sh_b[`NVCG_DELAY_MSB:0] == 3'h0) begin
          next_state = ST_RUN; // [RQ8]
        end else if (ms_cnt == MS_W'(MS_CYCLES - 1)) begin
          next_ms_cnt  = '0;
          next_ms_done = ms_done + 7'h01;
          if (ms_done + 7'h01 == nvcg_delay_ms(sh_b[`NVCG_DELAY_MSB:0])) begin
            next_state = ST_RUN; // [RQ8]
          end
        end else begin
          next_ms_cnt = ms_cnt + MS_W'(1);
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= ST_LOAD;
      ms_cnt  <= '0;
      ms_done <= 7'h00;
      sh_osc  <= 8'h00;
      sh_a    <= 8'h00;
      sh_b    <= 8'h00;
      sh_code <= 8'h00;
      sh_boot <= 8'h00;
    end else begin
      state   <= next_state;
      ms_cnt  <= next_ms_cnt;
      ms_done <= next_ms_done;
      sh_osc  <= next_osc;
      sh_a    <= next_a;
      sh_b    <= next_b;
      sh_code <= next_code;
      sh_boot <= next_boot;
    end
  end

  assign cpu_run            = (state == ST_RUN);
  assign default_osc_choice = sh_osc[`NVCG_OSC_SEL_MSB:0];
  assign internal_fast_osc  = (default_osc_choice == `NVCG_OSC_FAST); // [RQ1]
  assign internal_slow_osc  = (default_osc_choice == `NVCG_OSC_SLOW); // [RQ1]
  assign scan_region_sel    = sh_a[`NVCG_SCAN_REG_LSB +: 2]; // [RQ2]
  assign scan_disabled      = (scan_region_sel == `NVCG_SCAN_OFF); // [RQ2]
  assign scan_boot_and_app  = (scan_region_sel == 2'h2); // [RQ2]
  assign scan_poly_sel      = sh_a[`NVCG_SCAN_POLY_BIT]; // [RQ3]
  assign reset_pin_role     = sh_a[`NVCG_RST_ROLE_BIT]; // [RQ4]
  assign eeprom_retain      = sh_a[`NVCG_EE_RETAIN_BIT]; // [RQ5]
  assign supply_arrangement = sh_b[`NVCG_SUPPLY_LSB +: 2];
  assign multi_voltage_io   = (supply_arrangement == `NVCG_SUPPLY_DUAL); // [RQ7]
  assign supply_reserved    = (supply_arrangement != `NVCG_SUPPLY_DUAL) &&
                              (supply_arrangement != `NVCG_SUPPLY_SINGLE); // [RQ7]
  assign startup_delay_sel  = sh_b[`NVCG_DELAY_MSB:0];
  assign code_region_size   = sh_code;
  assign boot_region_size   = sh_boot;
  assign boot_all_flash     = (sh_boot == 8'h00); // [RQ10]
  assign boot_region_bytes  = {sh_boot, `NVCG_BLOCK_SHIFT'(0)}; // [RQ10]
  // code extent unused when boot covers all flash
  assign application_code_region = boot_all_flash ? 17'h00000 :
                                   {sh_code, `NVCG_BLOCK_SHIFT'(0)}; // [RQ9] [RQ10]

  // external path to plain memories; fuse and key served here
  logic ext_ok;
  logic ext_local;
  assign ext_ok     = ext_req && ext_acc.allow;
  assign ext_local  = (ext_region == RG_FUSE) || (ext_region == RG_LOCK);
  assign mem_req    = ext_ok && !ext_local; // [RQ13] [RQ15]
  assign mem_we     = ext_we;
  assign mem_region = ext_region;
  assign mem_addr   = ext_addr;
  assign mem_wdata  = ext_wdata;

  // non-volatile writes
  logic        fuse_we;
  logic [3:0]  fuse_idx;
  logic [7:0]  fuse_wdata;
  logic [31:0] next_key;
  always_comb begin
    fuse_idx   = ext_addr[3:0];
    fuse_we    = ext_ok && ext_we && (ext_region == RG_FUSE) &&
                 (ext_addr <= {4'h0, `NVCG_FUSE_LAST}); // [RQ20]
    fuse_wdata = ext_wdata & nvcg_mask(fuse_idx);
    next_key   = lock_key;
    if (factory_init) begin
      next_key = `NVCG_UNLOCK_KEY; // [RQ21]
    end else if (ext_erase) begin
      next_key = `NVCG_UNLOCK_KEY; // [RQ18]
    end else if (ext_ok && ext_we && (ext_region == RG_LOCK)) begin
      next_key[{ext_addr[1:0], 3'h0} +: 8] = ext_wdata; // [RQ12]
    end
  end

  always_ff @(posedge clk) begin
    if (factory_init) begin
      for (int i = 0; i <= 8; i++) begin
        fuse_mem[i] <= `NVCG_FACT_OTHER;
      end
      fuse_mem[`NVCG_OFS_CFGA] <= `NVCG_FACT_CFGA; // [RQ11]
      fuse_mem[`NVCG_OFS_CFGB] <= `NVCG_FACT_CFGB; // [RQ11]
    end else if (fuse_we && !ext_erase) begin
      fuse_mem[fuse_idx] <= fuse_wdata;
    end
    lock_key <= next_key;
  end

  // answers, one cycle after the request
  logic       next_cpu_ack, next_cpu_denied, next_ext_ack, next_ext_denied;
  logic [7:0] next_cpu_rdata, next_ext_rdata;
  logic       next_erase_flash, next_erase_eeprom;
  always_comb begin
    next_cpu_ack      = cpu_req;
    next_cpu_denied   = cpu_req && !cpu_acc.allow;
    next_cpu_rdata    = 8'h00;
    if (cpu_req && !cpu_we && cpu_region == RG_FUSE) begin
      next_cpu_rdata = fuse_mem[cpu_addr[3:0]] & nvcg_mask(cpu_addr[3:0]); // [RQ20]
    end else if (cpu_req && !cpu_we && cpu_region == RG_LOCK) begin
      next_cpu_rdata = nvcg_key_byte(lock_key, cpu_addr[1:0]);
    end
    next_ext_ack      = ext_req;
    next_ext_denied   = ext_req && !ext_acc.allow;
    next_ext_rdata    = 8'h00;
    if (ext_req && !ext_we) begin
      if (!ext_acc.allow) begin
        next_ext_rdata = `NVCG_DENY_DATA; // [RQ16] [RQ17]
      end else if (ext_region == RG_FUSE) begin
        next_ext_rdata = fuse_mem[ext_addr[3:0]] & nvcg_mask(ext_addr[3:0]);
      end else if (ext_region == RG_LOCK) begin
        next_ext_rdata = nvcg_key_byte(lock_key, ext_addr[1:0]);
      end else begin
        next_ext_rdata = mem_rdata;
      end
    end
    next_erase_flash  = ext_erase; // [RQ18]
    next_erase_eeprom = ext_erase && (locked || !eeprom_retain); // [RQ5] [RQ6]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_ack      <= 1'b0;
      cpu_denied   <= 1'b0;
      cpu_rdata    <= 8'h00;
      ext_ack      <= 1'b0;
      ext_denied   <= 1'b0;
      ext_rdata    <= 8'h00;
      erase_flash  <= 1'b0;
      erase_eeprom <= 1'b0;
    end else begin
      cpu_ack      <= next_cpu_ack;
      cpu_denied   <= next_cpu_denied;
      cpu_rdata    <= next_cpu_rdata;
      ext_ack      <= next_ext_ack;
      ext_denied   <= next_ext_denied;
      ext_rdata    <= next_ext_rdata;
      erase_flash  <= next_erase_flash;
      erase_eeprom <= next_erase_eeprom;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_load_osc;
    !sys_rst && state == ST_LOAD |=> default_osc_choice == $past(fuse_mem[`NVCG_OFS_OSC][3:0]);
  endproperty
  a_load_osc: assert property (p_load_osc) else $error("osc shadow not loaded"); // [RQ19]

  property p_shadow_hold;
    state == ST_RUN |=> $stable({sh_osc, sh_a, sh_b, sh_code, sh_boot});
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed in run"); // [RQ22]

  property p_no_delay;
    !sys_rst && state == ST_LOAD && fuse_mem[`NVCG_OFS_CFGB][2:0] == 3'h0 |=> ##1 cpu_run;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("zero delay not honoured"); // [RQ8]

  property p_erase_unlock;
    ext_erase && !factory_init |=> erase_flash && !locked;
  endproperty
  a_erase_unlock: assert property (p_erase_unlock) else $error("erase did not unlock"); // [RQ18]

  property p_locked_ee;
    ext_erase && locked |=> erase_eeprom;
  endproperty
  a_locked_ee: assert property (p_locked_ee) else $error("locked erase kept eeprom"); // [RQ6]

  property p_retain_ee;
    ext_erase && !locked && eeprom_retain |=> !erase_eeprom;
  endproperty
  a_retain_ee: assert property (p_retain_ee) else $error("retained eeprom erased"); // [RQ5]

  property p_deny_read;
    ext_req && !ext_we && locked |=> ext_ack && ext_denied && ext_rdata == `NVCG_DENY_DATA;
  endproperty
  a_deny_read: assert property (p_deny_read) else $error("locked read leaked"); // [RQ17]

  property p_locked_mem;
    locked && mem_req |-> mem_we && mem_region == RG_USER && ext_cfg_cmd;
  endproperty
  a_locked_mem: assert property (p_locked_mem) else $error("locked access passed"); // [RQ15]

  property p_cpu_cfg_wr;
    cpu_req && cpu_we && (cpu_region inside {RG_SIG, RG_FUSE, RG_LOCK}) |=> cpu_ack && cpu_denied;
  endproperty
  a_cpu_cfg_wr: assert property (p_cpu_cfg_wr) else $error("cpu protected write"); // [RQ14]

  property p_cpu_read;
    cpu_req && !cpu_we |=> cpu_ack && !cpu_denied;
  endproperty
  a_cpu_read: assert property (p_cpu_read) else $error("cpu read denied"); // [RQ13]

  property p_bad_key;
    ext_req && ext_we && ext_region == RG_LOCK && !locked && !ext_erase && !factory_init &&
    ext_wdata != nvcg_key_byte(`NVCG_UNLOCK_KEY, ext_addr[1:0]) |=> locked;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key left part open"); // [RQ12]
endmodule

// file: dv/nvcg_host_model.sv
// host tool model on the external program/debug port
`timescale 1ns/1ps
module nvcg_host_model (
  // clock
  input  wire logic             clk,
  // requests
  output logic                  ext_req,
  output logic                  ext_we,
  output logic                  ext_cfg_cmd,
  output logic                  ext_erase,
  output nvcg_pkg::nvcg_region_t ext_region,
  output logic [7:0]            ext_addr,
  output logic [7:0]            ext_wdata,
  // answers
  input  wire logic             ext_ack,
  input  wire logic             ext_denied,
  input  wire logic [7:0]       ext_rdata
);
  import nvcg_pkg::*;
  initial begin
    ext_req = 1'b0;
    ext_we = 1'b0;
    ext_cfg_cmd = 1'b0;
    ext_erase = 1'b0;
    ext_region = RG_FLASH;
    ext_addr = 8'h00;
    ext_wdata = 8'h00;
  end
  // qualifiers turned over after the pulse so stale values never match
  task automatic acc(input logic we, input logic cfg, input nvcg_region_t rg,
                     input logic [7:0] a, input logic [7:0] wd,
                     output logic ack, output logic den, output logic [7:0] rd);
    @(posedge clk);
    ext_req <= 1'b1;
    ext_we <= we;
    ext_cfg_cmd <= cfg;
    ext_region <= rg;
    ext_addr <= a;
    ext_wdata <= wd;
    @(posedge clk);
    ext_req <= 1'b0;
    ext_cfg_cmd <= 1'b0;
    ext_addr <= ~a;
    ext_wdata <= ~wd;
    #1;
    ack = ext_ack;
    den = ext_denied;
    rd = ext_rdata;
  endtask
  // full erase is the only way back out of the locked state
  task automatic erase();
    @(posedge clk);
    ext_erase <= 1'b1;
    @(posedge clk);
    ext_erase <= 1'b0;
    #1;
  endtask
endmodule

// file: dv/tb_nv_config_and_lock_guard.sv
// self-checking bench for the config loader and lock guard
`timescale 1ns/1ps
`include "nvcg_defs.svh"
module tb_nv_config_and_lock_guard;
  import nvcg_pkg::*;
  localparam int MS = 4;
  localparam int WD_CYCLES = 20000;
  localparam logic [39:0] MASK = {`NVCG_MASK_OSC, `NVCG_MASK_CFGA, `NVCG_MASK_CFGB, 16'hffff};
  logic clk, sys_rst, factory_init, cpu_req, cpu_we, cpu_ack, cpu_denied;
  logic ext_req, ext_we, ext_cfg_cmd, ext_erase, ext_ack, ext_denied;
  logic mem_req, mem_we, erase_flash, erase_eeprom, cpu_run, locked, mem_seen;
  logic internal_fast_osc, internal_slow_osc, scan_disabled, scan_boot_and_app;
  logic scan_poly_sel, reset_pin_role, eeprom_retain, multi_voltage_io, supply_reserved;
  logic boot_all_flash;
  nvcg_region_t cpu_region, ext_region, mem_region;
  logic [7:0] cpu_addr, cpu_rdata, ext_addr, ext_wdata, ext_rdata, mem_addr, mem_wdata;
  logic [7:0] mem_rdata, code_region_size, boot_region_size;
  logic [7:0] idle_pat = 8'h00;
  logic [3:0] default_osc_choice;
  logic [1:0] scan_region_sel, supply_arrangement;
  logic [2:0] startup_delay_sel;
  logic [16:0] boot_region_bytes, application_code_region;
  logic [39:0] prev;
  int error_cnt = 0;
  int cmp_count = 0;
  // per region, 1 = denied: cpu write, ext write open, ext read locked, ext write locked
  logic [3:0] perm_tbl [8] = '{4'h3, 4'h3, 4'h3, 4'h2, 4'hf, 4'hb, 4'hb, 4'h3};
  // fuse images osc, sys a, sys b, code, boot; row 0 is the factory image
  logic [39:0] rows [4] = '{40'h00_c0_08_00_00, 40'h01_29_12_10_04,
                            40'h02_48_07_ff_01, 40'hf5_bf_fb_20_00};
  logic [3:0] fuse_ofs [5] = '{`NVCG_OFS_OSC, `NVCG_OFS_CFGA, `NVCG_OFS_CFGB,
                               `NVCG_OFS_CODE, `NVCG_OFS_BOOT};

  nvcg_top #(.MS_CYCLES(MS)) uut (
    .clk, .sys_rst, .factory_init, .cpu_req, .cpu_we, .cpu_region, .cpu_addr, .cpu_ack,
    .cpu_denied, .cpu_rdata, .ext_req, .ext_we, .ext_cfg_cmd, .ext_erase, .ext_region,
    .ext_addr, .ext_wdata, .ext_ack, .ext_denied, .ext_rdata, .mem_req, .mem_we,
    .mem_region, .mem_addr, .mem_wdata, .mem_rdata, .erase_flash, .erase_eeprom, .cpu_run,
    .locked, .default_osc_choice, .internal_fast_osc, .internal_slow_osc, .scan_region_sel,
    .scan_disabled, .scan_boot_and_app, .scan_poly_sel, .reset_pin_role, .eeprom_retain,
    .supply_arrangement, .multi_voltage_io, .supply_reserved, .startup_delay_sel,
    .code_region_size, .boot_region_size, .boot_all_flash, .boot_region_bytes,
    .application_code_region
  );
  nvcg_host_model host (
    .clk, .ext_req, .ext_we, .ext_cfg_cmd, .ext_erase, .ext_region, .ext_addr, .ext_wdata,
    .ext_ack, .ext_denied, .ext_rdata
  );

  always #4 clk = ~clk;
  // idle memory bus moves every cycle so a late sample cannot pass
  always @(posedge clk) idle_pat <= idle_pat + 8'h3b;
  always @(posedge clk) mem_seen <= mem_req && {mem_we, mem_region, mem_wdata} ==
    {ext_we, ext_region, ext_wdata};
  assign mem_rdata = mem_req ? (mem_addr ^ 8'ha5) : idle_pat;

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cacc(input logic we, input nvcg_region_t rg, input logic [7:0] a,
                      output logic ack, output logic den, output logic [7:0] rd);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_region <= rg;
    cpu_addr <= a;
    @(posedge clk);
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    #1;
    ack = cpu_ack;
    den = cpu_denied;
    rd = cpu_rdata;
  endtask

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (9) @(posedge clk);
    #1;
    chk("held in reset", 3'h0, {cpu_run, cpu_ack, erase_flash});
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic startup(input logic [2:0] d);
    int n;
    int e;
    int tol;
    n = 0;
    e = (d == 3'h0) ? 2 : 2 + (1 << (d - 1)) * MS;
    tol = (d == 3'h0) ? 0 : 2;
    while (cpu_run !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_count++;
    if (n < e - tol || n > e + tol) begin
      error_cnt++;
      $display("[ERR] start-up edges expected %0d seen %0d", e, n);
    end
  endtask

  task automatic check_cfg(input logic [39:0] raw);
    logic [39:0] s;
    logic ack, den;
    logic [7:0] rd;
    s = raw & MASK;
    for (int i = 0; i < 5; i++) begin
      cacc(1'b0, RG_FUSE, {4'h0, fuse_ofs[i]}, ack, den, rd);
      chk("fuse read", {2'b10, s[39 - 8 * i -: 8]}, {ack, den, rd});
    end
    chk("osc", {s[35:32], s[35:32] == 4'h0, s[35:32] == 4'h1},
        {default_osc_choice, internal_fast_osc, internal_slow_osc});
    chk("scan", {s[31:30], s[31:30] == 2'h3, s[31:30] == 2'h2, s[29]},
        {scan_region_sel, scan_disabled, scan_boot_and_app, scan_poly_sel});
    chk("pin retain", {s[27], s[24]}, {reset_pin_role, eeprom_retain});
    chk("supply", {s[20:19], s[20:19] == 2'h1, s[20:19] == 2'h0 || s[20:19] == 2'h3},
        {supply_arrangement, multi_voltage_io, supply_reserved});
    chk("delay", s[18:16], startup_delay_sel);
    chk("sizes", {s[15:0], s[7:0] == 8'h0},
        {code_region_size, boot_region_size, boot_all_flash});
    chk("bytes", {s[7:0], 9'h0, (s[7:0] == 8'h0) ? 17'h0 : {s[15:8], 9'h0}},
        {boot_region_bytes, application_code_region});
    host.erase();
    chk("open erase", {1'b1, ~s[24], 1'b0}, {erase_flash, erase_eeprom, locked});
  endtask

  task automatic perm_pass(input logic lk);
    logic ack, den, mx;
    logic [7:0] rd;
    nvcg_region_t rg;
    for (int i = 0; i < 8; i++) begin
      rg = nvcg_region_t'(i);
      cacc(1'b0, rg, 8'h20, ack, den, rd);
      chk("cpu read", 2'b10, {ack, den});
      cacc(1'b1, rg, 8'h20, ack, den, rd);
      chk("cpu write", {1'b1, perm_tbl[i][3]}, {ack, den});
      host.acc(1'b0, rg == RG_USER, rg, 8'h20, 8'h5c, ack, den, rd);
      mx = !lk && rg != RG_FUSE && rg != RG_LOCK;
      chk("ext read", {1'b1, lk, mx}, {ack, den, mem_seen});
      if (lk) chk("ext read data", 8'hff, rd);
      else if (mx) chk("ext read data", 8'h85, rd);
      host.acc(1'b1, rg == RG_USER, rg, (rg == RG_LOCK) ? 8'h00 : 8'h20, 8'h5c,
               ack, den, rd);
      chk("ext write", {1'b1, lk ? perm_tbl[i][0] : perm_tbl[i][2]}, {ack, den});
      mx = rg != RG_FUSE && rg != RG_LOCK && !perm_tbl[i][lk ? 0 : 2];
      chk("mem write", mx, mem_seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end
    else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (WD_CYCLES) @(posedge clk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict();
  end

  initial begin
    logic ack, den;
    logic [7:0] rd;
    clk = 1'b0;
    sys_rst = 1'b1;
    factory_init = 1'b1;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_region = RG_FLASH;
    cpu_addr = 8'h00;
    @(posedge clk);
    factory_init <= 1'b0;
    do_reset();
    startup(3'h0);
    chk("factory lock", 1'b0, locked);
    check_cfg(rows[0]);
    prev = rows[0] & MASK;
    $display("test factory image done");
    for (int r = 1; r < 4; r++) begin
      for (int i = 0; i < 5; i++) begin
        host.acc(1'b1, 1'b0, RG_FUSE, {4'h0, fuse_ofs[i]}, rows[r][39 - 8 * i -: 8],
                 ack, den, rd);
        chk("fuse write", 2'b10, {ack, den});
      end
      chk("shadow held", prev[23:0],
          {3'h0, supply_arrangement, startup_delay_sel, code_region_size, boot_region_size});
      do_reset();
      startup(rows[r][18:16]);
      check_cfg(rows[r]);
      prev = rows[r] & MASK;
      $display("test fuse image %0d done", r);
    end
    perm_pass(1'b0);
    $display("test open access done");
    host.acc(1'b1, 1'b0, RG_LOCK, 8'h03, 8'h00, ack, den, rd);
    chk("bad key", 3'b101, {ack, den, locked});
    perm_pass(1'b1);
    host.acc(1'b1, 1'b0, RG_USER, 8'h01, 8'h77, ack, den, rd);
    chk("user write plain", 2'b11, {ack, den});
    host.acc(1'b0, 1'b1, RG_USER, 8'h01, 8'h00, ack, den, rd);
    chk("user read", 10'h3ff, {ack, den, rd});
    $display("test locked access done");
    host.erase();
    chk("locked erase", 3'b110, {erase_flash, erase_eeprom, locked});
    host.acc(1'b0, 1'b0, RG_LOCK, 8'h01, 8'h00, ack, den, rd);
    chk("key byte", 10'h2c5, {ack, den, rd});
    $display("test erase unlock done");
    give_verdict();
  end
endmodule
